//--- verilog/dialler_pkg.sv
// constants, types and a timing function shared by the pulse dialler
package dialler_pkg;

  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ = 250000000;
  localparam int DIAL_KHZ = 18;
  localparam int TICK_DIV = SYS_CLK_HZ / (DIAL_KHZ * 1000);
  localparam int DIGITS = 20;

  // debounce: least time, rounded up to whole ticks
  localparam int DEBOUNCE_US = 8500;
  localparam logic [15:0] DEBOUNCE_TICKS =
    16'((DEBOUNCE_US * DIAL_KHZ + 999) / 1000);

  // ---------------------------------------------------------------
  // pulse rates and mark/space split
  // ---------------------------------------------------------------
  localparam int RATE_SLOW_PPS = 10;
  localparam int RATE_MID_PPS = 20;
  localparam int RATE_FAST_PPS = 600;
  localparam logic [15:0] PERIOD_SLOW = 16'(DIAL_KHZ * 1000 / RATE_SLOW_PPS);
  localparam logic [15:0] PERIOD_MID = 16'(DIAL_KHZ * 1000 / RATE_MID_PPS);
  localparam logic [15:0] PERIOD_FAST = 16'(DIAL_KHZ * 1000 / RATE_FAST_PPS);
  localparam logic [5:0] RATIO_DEN = 6'h1e;
  localparam logic [5:0] MARK_70 = 6'h15;
  localparam logic [5:0] MARK_50 = 6'h0f;
  localparam logic [5:0] MARK_TWO_THIRDS = 6'h14;
  localparam logic [5:0] MARK_60 = 6'h12;

  // ---------------------------------------------------------------
  // inter-digit pauses, per rate and pause select
  // ---------------------------------------------------------------
  localparam int IDP_SLOW_PH2_US = 400000;
  localparam int IDP_SLOW_LOW_US = 800000;
  localparam int IDP_SLOW_PH1_US = 1000000;
  localparam int IDP_MID_PH2_US = 200000;
  localparam int IDP_MID_LOW_US = 400000;
  localparam int IDP_MID_PH1_US = 500000;
  localparam int IDP_FAST_PH2_US = 6660;
  localparam int IDP_FAST_LOW_US = 13330;
  localparam int IDP_FAST_PH1_US = 18330;

  function automatic logic [15:0] us_to_ticks(input int us);
    return 16'((us * DIAL_KHZ + 500) / 1000);
  endfunction

  // ---------------------------------------------------------------
  // option select codes (four-level pins become two-bit codes)
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_PH1 = 2'h0;
  localparam logic [1:0] SEL_PH2 = 2'h1;
  localparam logic [1:0] SEL_LOW = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;

  localparam logic [3:0] KEY_AP_CODE = 4'hf;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_RATIO_LSB = 2;
  localparam int CTRL_PAUSE_LSB = 4;
  localparam logic [5:0] CTRL_RESET = 6'h2a;
  localparam int ST_RD_LSB = 8;
  localparam int ST_STATE_LSB = 16;
  localparam int ST_HOLD_BIT = 20;
  localparam int ST_PEND_BIT = 21;

  typedef struct packed {
    logic [1:0] pause;
    logic [1:0] ratio;
    logic [1:0] rate;
  } opt_s;

  typedef struct packed {
    logic valid;
    logic [3:0] code;
  } key_s;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PREPAUSE = 3'b001,
    S_MARK = 3'b010,
    S_SPACE = 3'b011,
    S_IDP = 3'b100,
    S_APAUSE = 3'b101,
    S_DONE = 3'b110
  } state_e;

endpackage

//--- verilog/push_button_pulse_dialler.sv
// push-button keyboard to loop-disconnect pulse dialler with redial
// Function
// - reset low clears digit store and all counters
// - store holds one number of at most 20 digits
// - mute low while entering or dialling, high in access pause and done
// - access pause output low while an access pause is required
// - redial output low while redial mode is selected
// - low keyboard strobe reads inhibit or key code, nothing otherwise
// - key codes map to digits 1..9, 0 as ten, access pause
// - rate select gives 600, 20 or 10 pulses per second
// - line output low during mark, high during space
// - ratio select gives 70/30, 50/50, 2/3-1/3, 60/40
// - mark and space come from exact tick division
// - digit strobe low while a digit is outpulsed
// - inhibit toggles redial mode outside access pause
// - toggle before keying: digits stored, dialling waits for toggle
// - toggle while dialling halts; next toggle resumes
// - toggle after completion keeps number; next toggle redials it
// - in access pause inhibit is a level gate on outpulsing
// - pause select sets inter-digit pause per rate
// - pre-digit pause equal to inter-digit pause before first digit
// - all timing in fixed counts of the 18 kHz tick
// - strobe must stay low 8.5 ms before code is taken
// - invalid key codes are dropped
// - stored digits read without destroying them
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module push_button_pulse_dialler
  import dialler_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_DIV,
  parameter int MAX_DIGITS = DIGITS
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic KBD_STROBE_N,
  input wire logic [3:0] KEY_CODE_INPUTS,
  input wire logic INHIBIT,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic REDIAL_N,
  output logic ACCESS_PAUSE_N,
  output logic MUTE_N,
  output logic LINE_N,
  output logic DIGIT_STROBE_N
);

  localparam int IW = $clog2(MAX_DIGITS + 1);

  // ---------------------------------------------------------------
  // timing and key decode functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] period_ticks(input logic [1:0] rate);
    case (rate)
      SEL_PH1: return PERIOD_FAST;
      SEL_PH2: return PERIOD_MID;
      default: return PERIOD_SLOW;
    endcase
  endfunction

  // exact integer split of the period, independent of tick rate
  function automatic logic [15:0] mark_ticks(input logic [1:0] rate,
                                             input logic [1:0] ratio);
    logic [5:0] num;
    logic [31:0] prod;
    case (ratio)
      SEL_PH1: num = MARK_70;
      SEL_PH2: num = MARK_50;
      SEL_LOW: num = MARK_TWO_THIRDS;
      default: num = MARK_60;
    endcase
    prod = 32'(period_ticks(rate)) * 32'(num);
    return 16'(prod / 32'(RATIO_DEN));
  endfunction

  function automatic logic [15:0] idp_ticks(input logic [1:0] rate,
                                            input logic [1:0] pause);
    logic [15:0] t;
    case (rate)
      SEL_PH1: begin
        t = (pause == SEL_PH2) ? us_to_ticks(IDP_FAST_PH2_US) :
            (pause == SEL_PH1) ? us_to_ticks(IDP_FAST_PH1_US) :
            us_to_ticks(IDP_FAST_LOW_US);
      end
      SEL_PH2: begin
        t = (pause == SEL_PH2) ? us_to_ticks(IDP_MID_PH2_US) :
            (pause == SEL_PH1) ? us_to_ticks(IDP_MID_PH1_US) :
            us_to_ticks(IDP_MID_LOW_US);
      end
      default: begin
        t = (pause == SEL_PH2) ? us_to_ticks(IDP_SLOW_PH2_US) :
            (pause == SEL_PH1) ? us_to_ticks(IDP_SLOW_PH1_US) :
            us_to_ticks(IDP_SLOW_LOW_US);
      end
    endcase
    return t;
  endfunction

  function automatic key_s key_decode(input logic [3:0] c);
    key_s k;
    k.valid = 1'b1;
    case (c)
      4'hf: k.code = 4'h1;
      4'he: k.code = 4'h2;
      4'hd: k.code = 4'h3;
      4'hb: k.code = 4'h4;
      4'ha: k.code = 4'h5;
      4'h9: k.code = 4'h6;
      4'h7: k.code = 4'h7;
      4'h6: k.code = 4'h8;
      4'h5: k.code = 4'h9;
      4'hc: k.code = 4'ha;
      4'h3: k.code = KEY_AP_CODE;
      default: begin
        k.valid = 1'b0;
        k.code = 4'h0;
      end
    endcase
    return k;
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [5:0] pin_m_q;
  logic [5:0] pin_s_q;
  logic [15:0] tick_cnt_q;
  logic tick_q;
  opt_s opt_q;
  opt_s opt_live_q;
  logic [15:0] deb_cnt_q;
  logic taken_q;
  logic hold_q;
  logic [IW-1:0] wr_cnt_q;
  logic [IW-1:0] rd_idx_q;
  logic [IW-1:0] rd_idx_d;
  logic [3:0] store_q [MAX_DIGITS+1];
  state_e state_q;
  state_e state_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [3:0] pulses_q;
  logic [3:0] pulses_d;
  logic load;
  logic ack_q;
  logic [31:0] dat_q;
  logic redial_q;
  logic ap_q;
  logic mute_q;
  logic line_q;
  logic dstrobe_q;

  // ---------------------------------------------------------------
  // pin synchronisers and tick divider
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pin_m_q <= 6'h3f;
      pin_s_q <= 6'h3f;
    end else begin
      pin_m_q <= {KBD_STROBE_N, INHIBIT, KEY_CODE_INPUTS};
      pin_s_q <= pin_m_q;
    end
  end

  wire strobe_low = !pin_s_q[5];
  wire inh_s = pin_s_q[4];
  wire [3:0] code_s = pin_s_q[3:0];
  wire tick_wrap = tick_cnt_q == 16'(TICK_CYCLES - 1);

  // one tick stands in for one period of the two-phase clock
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      tick_cnt_q <= 16'h0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? 16'h0 : tick_cnt_q + 16'h1;
      tick_q <= tick_wrap;
    end
  end

  // selects only move on a tick; a rewrite during a mark still sets the space of that pulse
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      opt_live_q <= CTRL_RESET;
    end else if (tick_q) begin
      opt_live_q <= opt_q;
    end
  end

  // ---------------------------------------------------------------
  // keyboard debounce and decode
  // ---------------------------------------------------------------
  // one tick past the count so a strobe caught just before a tick still
  // sees the full debounce time
  wire deb_full = deb_cnt_q > DEBOUNCE_TICKS;
  wire acc = strobe_low && deb_full && !taken_q;
  wire in_ap = state_q == S_APAUSE;
  // outside an access pause inhibit is only trusted while the keyboard holds the strobe low
  wire acc_inh = acc && inh_s;
  wire acc_key = acc && !inh_s;
  wire toggle = acc_inh && !in_ap;
  key_s kd;
  assign kd = key_decode(code_s);
  wire store_en = acc_key && kd.valid &&
                  (wr_cnt_q < IW'(MAX_DIGITS));

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !strobe_low) begin
      deb_cnt_q <= 16'h0;
      taken_q <= 1'b0;
    end else begin
      if (tick_q && !deb_full) begin
        deb_cnt_q <= deb_cnt_q + 16'h1;
      end
      if (acc) begin
        taken_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // digit store and redial mode
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wr_cnt_q <= '0;
      for (int i = 0; i <= MAX_DIGITS; i++) begin
        store_q[i] <= 4'h0;
      end
    end else if (store_en) begin
      store_q[wr_cnt_q] <= kd.code;
      wr_cnt_q <= wr_cnt_q + IW'(1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      hold_q <= 1'b0;
    end else if (toggle) begin
      hold_q <= !hold_q;
    end
  end

  // ---------------------------------------------------------------
  // outpulsing state machine
  // ---------------------------------------------------------------
  // the spare slot past the last digit is never written and reads 0
  wire [3:0] cur_code = store_q[rd_idx_q];
  wire pending = rd_idx_q < wr_cnt_q;
  wire [15:0] mark_t = mark_ticks(opt_live_q.rate, opt_live_q.ratio);
  wire [15:0] space_t = period_ticks(opt_live_q.rate) - mark_t;
  wire [15:0] idp_t = idp_ticks(opt_live_q.rate, opt_live_q.pause);
  wire expire = tick_q && (cnt_q <= 16'h1);
  wire restart = toggle && hold_q && (state_q == S_DONE) &&
                 (wr_cnt_q != '0);

  always_comb begin
    state_d = state_q;
    cnt_d = (tick_q && cnt_q > 16'h1) ? cnt_q - 16'h1 : cnt_q;
    pulses_d = pulses_q;
    rd_idx_d = rd_idx_q;
    load = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (pending && !hold_q) begin
          state_d = S_PREPAUSE;
          cnt_d = idp_t;
        end
      end
      S_PREPAUSE: begin
        load = expire && !hold_q;
      end
      S_MARK: begin
        if (expire) begin
          state_d = S_SPACE;
          cnt_d = space_t;
        end
      end
      S_SPACE: begin
        if (expire) begin
          if (pulses_q == 4'h1) begin
            rd_idx_d = rd_idx_q + IW'(1);
            state_d = S_IDP;
            cnt_d = idp_t;
          end else begin
            pulses_d = pulses_q - 4'h1;
            state_d = S_MARK;
            cnt_d = mark_t;
          end
        end
      end
      S_IDP: begin
        // a halt is taken at the digit boundary, never inside a pulse
        if (expire && !hold_q) begin
          if (pending) begin
            load = 1'b1;
          end else begin
            state_d = S_DONE;
          end
        end
      end
      S_APAUSE: begin
        if (expire && !inh_s) begin
          rd_idx_d = rd_idx_q + IW'(1);
          state_d = S_IDP;
          cnt_d = idp_t;
        end
      end
      S_DONE: begin
        if (restart) begin
          rd_idx_d = '0;
          state_d = S_PREPAUSE;
          cnt_d = idp_t;
        end else if (pending && !hold_q) begin
          load = 1'b1;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (load) begin
      if (cur_code == KEY_AP_CODE) begin
        state_d = S_APAUSE;
        cnt_d = idp_t;
      end else begin
        state_d = S_MARK;
        pulses_d = cur_code;
        cnt_d = mark_t;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_q <= S_IDLE;
      cnt_q <= 16'h0;
      pulses_q <= 4'h0;
      rd_idx_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pulses_q <= pulses_d;
      rd_idx_q <= rd_idx_d;
    end
  end

  // ---------------------------------------------------------------
  // line side outputs
  // ---------------------------------------------------------------
  wire busy = (state_q == S_PREPAUSE) || (state_q == S_MARK) ||
              (state_q == S_SPACE) || (state_q == S_IDP);
  wire mute_on = busy || (pending && !in_ap);
  wire digit_on = (state_q == S_MARK) || (state_q == S_SPACE);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      redial_q <= 1'b1;
      ap_q <= 1'b1;
      mute_q <= 1'b1;
      line_q <= 1'b1;
      dstrobe_q <= 1'b1;
    end else begin
      redial_q <= !hold_q;
      ap_q <= !in_ap;
      mute_q <= !mute_on;
      line_q <= state_q != S_MARK;
      dstrobe_q <= !digit_on;
    end
  end

  assign REDIAL_N = redial_q;
  assign ACCESS_PAUSE_N = ap_q;
  assign MUTE_N = mute_q;
  assign LINE_N = line_q;
  assign DIGIT_STROBE_N = dstrobe_q;

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  // unmapped addresses still ack, read zero and drop writes
  wire wb_req = WB_CYC_I && WB_STB_I && !ack_q;
  wire hit_ctrl = WB_ADR_I == REG_CTRL;
  wire hit_status = WB_ADR_I == REG_STATUS;
  wire ctrl_we = wb_req && WB_WE_I && hit_ctrl && WB_SEL_I[0];
  wire [31:0] status_w = 32'(wr_cnt_q) |
                         (32'(rd_idx_q) << ST_RD_LSB) |
                         (32'(state_q) << ST_STATE_LSB) |
                         (32'(hold_q) << ST_HOLD_BIT) |
                         (32'(pending) << ST_PEND_BIT);
  wire [31:0] rd_mux = hit_ctrl ? 32'(opt_q) :
                       hit_status ? status_w : 32'h0;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      opt_q <= CTRL_RESET;
    end else begin
      ack_q <= wb_req;
      dat_q <= (wb_req && !WB_WE_I) ? rd_mux : 32'h0;
      if (ctrl_we) begin
        opt_q <= WB_DAT_I[5:0];
      end
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_reset_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(RST_N) |-> (wr_cnt_q == '0) && (state_q == S_IDLE))
    else $error("store or state not cleared by reset");
  a_store_depth: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr_cnt_q <= IW'(MAX_DIGITS))
    else $error("digit store overfilled");
  a_mute_dial: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state_q == S_MARK) ##1 (state_q == S_MARK) |-> !MUTE_N)
    else $error("mute released during a mark");
  a_ap_output: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    in_ap |=> !ACCESS_PAUSE_N && MUTE_N)
    else $error("access pause outputs wrong");
  a_redial_out: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    toggle && !hold_q |=> ##1 !REDIAL_N)
    else $error("redial output not low in redial mode");
  a_line_mark: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state_q == S_MARK) |=> !LINE_N && !DIGIT_STROBE_N)
    else $error("line not in break during mark");
  a_mark_load: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state_q != S_MARK && state_d == S_MARK) |=>
      cnt_q == $past(mark_t))
    else $error("mark length not loaded");
  a_pulse_count: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    load && (cur_code != KEY_AP_CODE) |=>
      pulses_q == $past(cur_code))
    else $error("pulse count differs from stored digit");
  a_halt_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state_q == S_IDP) && hold_q |=> state_q == S_IDP)
    else $error("dialling continued while halted");
  a_ap_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    in_ap && inh_s |=> in_ap && $stable(hold_q))
    else $error("inhibit did not gate the access pause");
  a_hold_toggle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    toggle |=> hold_q != $past(hold_q))
    else $error("inhibit did not toggle redial mode");
  a_prepause: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state_d == S_PREPAUSE && state_q != S_PREPAUSE) |=>
      cnt_q == $past(idp_t))
    else $error("pre-digit pause length wrong");
  a_debounce: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    acc |-> strobe_low && deb_cnt_q == DEBOUNCE_TICKS + 16'h1)
    else $error("key taken before debounce time");
  a_bad_key: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    acc_key && !kd.valid |=> $stable(wr_cnt_q))
    else $error("invalid key code stored");

endmodule

//--- testbench/dial_partner.sv
// keyboard and line-side model for the pulse dialler bench
`timescale 1ns/1ns
module dial_partner (
  input wire logic CLK_SYS,
  input wire logic LINE_N,
  input wire logic MUTE_N,
  input wire logic DIGIT_STROBE_N,
  output logic KBD_STROBE_N,
  output logic [3:0] KEY_CODE_INPUTS,
  output logic INHIBIT
);
  int marks = 0;
  int mark_len = 0;
  int run = 0;
  int bad = 0;
  int since_mute = 0;
  int pre = 0;
  logic line_q = 1'b1;
  logic mute_q = 1'b1;
  logic armed = 1'b0;
  // ---------------------------------------------------------------
  // keyboard
  // ---------------------------------------------------------------
  initial begin
    KBD_STROBE_N = 1'b1;
    KEY_CODE_INPUTS = 4'hf;
    INHIBIT = 1'b0;
  end
  // held well past the debounce time; idle strobe and code lines sit at logic 1, inhibit at 0
  task automatic press(input logic [3:0] code, input logic inh);
    @(posedge CLK_SYS);
    KBD_STROBE_N <= 1'b0;
    KEY_CODE_INPUTS <= code;
    INHIBIT <= inh;
    repeat (700) @(posedge CLK_SYS);
    INHIBIT <= 1'b0;
    @(posedge CLK_SYS);
    KBD_STROBE_N <= 1'b1;
    KEY_CODE_INPUTS <= 4'hf;
    repeat (20) @(posedge CLK_SYS);
  endtask
  // inside an access pause inhibit is a plain level, no strobe needed
  task automatic gate(input logic lvl);
    @(posedge CLK_SYS);
    INHIBIT <= lvl;
  endtask
  // ---------------------------------------------------------------
  // line side: counts breaks, mark length, pre-digit gap
  // ---------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    line_q <= LINE_N;
    mute_q <= MUTE_N;
    since_mute <= (MUTE_N === 1'b1) ? 0 : since_mute + 1;
    if (mute_q === 1'b1 && MUTE_N === 1'b0) begin
      armed <= 1'b1;
    end
    if (armed && line_q === 1'b1 && LINE_N === 1'b0) begin
      pre <= since_mute;
      armed <= 1'b0;
    end
    if (LINE_N === 1'b0) begin
      run <= run + 1;
      if (DIGIT_STROBE_N !== 1'b0 || MUTE_N !== 1'b0) begin
        bad <= bad + 1;
      end
    end
    if (line_q === 1'b0 && LINE_N === 1'b1) begin
      marks <= marks + 1;
      mark_len <= run;
      run <= 0;
    end
  end
endmodule

//--- testbench/test_push_button_pulse_dialler.sv
// self-checking bench for the push-button pulse dialler
`timescale 1ns/1ns
module test_push_button_pulse_dialler;
  import dialler_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, redial_n, ap_n, mute_n, line_n, dstb_n, strobe_n, inh;
  logic [3:0] code;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int base;
  logic [3:0] keys [4] = '{4'hf, 4'hc, 4'ha, 4'h5};
  int pulses [4] = '{1, 10, 5, 9};
  int mark_ticks [4] = '{21, 15, 20, 18};
  push_button_pulse_dialler #(.TICK_CYCLES(4)) i_dut (.CLK_SYS(clk_sys),
    .RST_N(rst_n), .KBD_STROBE_N(strobe_n), .KEY_CODE_INPUTS(code),
    .INHIBIT(inh), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .REDIAL_N(redial_n), .ACCESS_PAUSE_N(ap_n),
    .MUTE_N(mute_n), .LINE_N(line_n), .DIGIT_STROBE_N(dstb_n));
  dial_partner i_kbd (.CLK_SYS(clk_sys), .LINE_N(line_n),
    .MUTE_N(mute_n), .DIGIT_STROBE_N(dstb_n), .KBD_STROBE_N(strobe_n),
    .KEY_CODE_INPUTS(code), .INHIBIT(inh));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // waits bounded; a missing end of dialling shows in the pulse counts
  task automatic wait_mute(input int lim);
    int n;
    n = 0;
    while (mute_n !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    check({27'h0, redial_n, ap_n, mute_n, line_n, dstb_n}, 32'h1f);
    rst_n <= 1'b1;
    wb(1'b0, REG_CTRL, 32'h0, q);
    check(q, {26'h0, CTRL_RESET});
    wb(1'b0, REG_STATUS, 32'h0, q);
    check(q, 32'h0);
    wb(1'b0, 8'h10, 32'h0, q);
    check(q, 32'h0);
    // fast rate and short pause keep the run small
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, REG_CTRL, 32'h10 | 32'(i << 2), q);
      wb(1'b0, REG_CTRL, 32'h0, q);
      check(q, 32'h10 | 32'(i << 2));
      base = i_kbd.marks;
      i_kbd.press(keys[i], 1'b0);
      wait_mute(8000);
      check(32'(i_kbd.marks - base), 32'(pulses[i]));
      check(32'(i_kbd.mark_len >= mark_ticks[i] * 4 - 4 &&
                i_kbd.mark_len <= mark_ticks[i] * 4 + 4), 32'h1);
      if (i == 0) begin
        check(32'(i_kbd.pre >= 472 && i_kbd.pre <= 488), 32'h1);
      end
    end
    base = i_kbd.marks;
    i_kbd.press(4'h0, 1'b0);
    wb(1'b0, REG_STATUS, 32'h0, q);
    check(q & 32'h1f, 32'h4);
    check(32'(mute_n), 32'h1);
    i_kbd.press(4'h7, 1'b1);
    check(32'(redial_n), 32'h0);
    wb(1'b0, REG_STATUS, 32'h0, q);
    check(32'(q[ST_HOLD_BIT]), 32'h1);
    check(32'(i_kbd.marks - base), 32'h0);
    i_kbd.press(4'h7, 1'b1);
    check(32'(redial_n), 32'h1);
    wait_mute(20000);
    check(32'(i_kbd.marks - base), 32'd25);
    wb(1'b0, REG_STATUS, 32'h0, q);
    check(q & 32'h1f, 32'h4);
    check(32'(i_kbd.bad), 32'h0);
    check(32'(ap_n), 32'h1);
    // access pause: mute released, inhibit held high gates the exit
    base = i_kbd.marks;
    i_kbd.press(4'h3, 1'b0);
    check({30'h0, ap_n, mute_n}, 32'h1);
    i_kbd.gate(1'b1);
    repeat (1000) @(posedge clk_sys);
    check({30'h0, ap_n, redial_n}, 32'h1);
    i_kbd.gate(1'b0);
    repeat (700) @(posedge clk_sys);
    check({30'h0, ap_n, mute_n}, 32'h3);
    check(32'(i_kbd.marks - base), 32'h0);
    wb(1'b0, REG_STATUS, 32'h0, q);
    check(q, 32'h00060505);
    report_and_stop;
  end
endmodule
